// ---- logic/plc_compare_and_timers.sv ----
// Purpose: compare unit, run control and four low-speed timers
// Assumes: AHB-Lite single word transfers, one clock, async low reset
// Notes: registers answer with zero wait states, always OKAY
//
// How it works
// - first operand lower: flag n set, flags n+1 and n+2 cleared
// - first operand higher: flags n and n+1 cleared, flag n+2 set
// - operands equal: same flag pattern as higher
// - unsigned compare treats operands as 32-bit magnitudes
// - signed compare treats operands as 32-bit two's complement
// - each operand comes from register area or parameter area, the first also from a constant
// - flags land in bit area starting at the destination bit
// - only the first operand may be an immediate constant
// - program runs only while run enable holds 1, default 0
// - controller reset at 1 resets the controller, 0 leaves it
// - timer1 mode 0 holds at set value, 1 counts past it; timers 2 to 4 always hold
// - timer1 source 0 ticks every 10 ms, 1 every 100 ms
// - timer1 source 2 counts edges of the source bit input
// - set values signed within +-2147483647, default 0, take effect now
// - four independent timers, each with its own set value
// - each timer current value is readable, signed
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module plc_compare_and_timers #(
    parameter int unsigned TICK_SHORT_CYC =
        plc_pkg::TICK_SHORT_MS * plc_pkg::CLK_KHZ,
    parameter int unsigned TICK_LONG_CYC =
        plc_pkg::TICK_LONG_MS * plc_pkg::CLK_KHZ
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // external count source, asynchronous pin
    input wire logic timer1_source_bit,
    // controller state
    output logic program_running,
    output logic controller_reset,
    output logic [15:0] program_line,
    output logic [15:0] bit_area
);
    import plc_pkg::*;

    // compare outcome: bit0 is flag n, bit2 is flag n+2
    function automatic logic [2:0] cmp_flags(input logic [31:0] a,
        input logic [31:0] b, input logic sgn);
        logic lower;
        lower = sgn ? ($signed(a) < $signed(b)) : (a < b);
        cmp_flags = lower ? 3'b001 : 3'b100;
    endfunction

    // one timer step; saturates rather than wrapping into the negatives
    function automatic logic [31:0] timer_next(input logic [31:0] cur,
        input logic [31:0] set, input logic hold, input logic tick);
        timer_next = cur;
        if (tick && !(hold && $signed(cur) >= $signed(set)) &&
            cur != VALUE_MAX) begin
            timer_next = cur + 32'h0000_0001;
        end
    endfunction

    // register state
    logic run_r;
    logic [15:0] start_line_r;
    logic ctl_rst_r;
    logic [15:0] t1_cfg_r;
    logic [31:0] set_r [4];
    logic [31:0] cur_r [4];
    logic [31:0] gen_r [4];
    logic [31:0] par_r [4];
    logic [15:0] cmp_ctl_r;
    logic [31:0] cmp_imm_r;
    logic [15:0] bit_area_r;
    logic err_r;
    logic [15:0] program_line_r;
    logic running_d_r;
    logic go_r;
    logic [3:0] last_dest_r;

    // bus pipeline
    logic wr_r;
    logic [7:0] wr_addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] prescale_s_r;
    logic [31:0] prescale_l_r;
    logic src_meta_r;
    logic src_sync_r;
    logic src_prev_r;

    // address phase decode; only whole words are accepted
    wire addr_ok = hsel && hready && htrans[1] && hsize == 3'b010;
    wire [7:0] a_addr = haddr[7:0];
    wire unmapped = |haddr[31:8] || a_addr[1:0] != 2'b00 ||
        a_addr > OFS_PAR_BASE + 8'h0C;
    wire wr_set = addr_ok && hwrite && !unmapped;
    // a narrow read is still answered, with zero, so stale data never shows
    wire rd_set = hsel && hready && htrans[1] && !hwrite;
    wire [1:0] wr_idx = wr_addr_r[3:2];
    wire [1:0] rd_idx = a_addr[3:2];

    // data phase write strobes
    wire w_run = wr_r && wr_addr_r == OFS_RUN_ENABLE;
    wire w_line = wr_r && wr_addr_r == OFS_START_LINE;
    wire w_crst = wr_r && wr_addr_r == OFS_CTRL_RESET;
    wire w_cfg = wr_r && wr_addr_r == OFS_T1_CONFIG;
    wire w_set = wr_r && wr_addr_r[7:4] == OFS_SET_BASE[7:4];
    wire w_ctl = wr_r && wr_addr_r == OFS_CMP_CONTROL;
    wire w_imm = wr_r && wr_addr_r == OFS_CMP_IMMEDIATE;
    wire w_bits = wr_r && wr_addr_r == OFS_BIT_AREA;
    wire w_gen = wr_r && wr_addr_r[7:4] == OFS_GEN_BASE[7:4];
    wire w_par = wr_r && wr_addr_r[7:4] == OFS_PAR_BASE[7:4];

    // run control
    wire running = run_r && !ctl_rst_r;
    wire run_rise = running && !running_d_r;

    // tick sources, stopped and restarted with the controller
    wire tick_s = running && prescale_s_r == TICK_SHORT_CYC - 1;
    wire tick_l = running && prescale_l_r == TICK_LONG_CYC - 1;
    wire tick_b = running && src_sync_r && !src_prev_r;
    wire [3:0] t1_src = t1_cfg_r[CFG_SRC_LSB +: 4];
    wire [3:0] t1_mode = t1_cfg_r[CFG_MODE_LSB +: 4];
    wire t1_tick = (t1_src == SRC_TICK_SHORT) ? tick_s :
        (t1_src == SRC_TICK_LONG) ? tick_l :
        (t1_src == SRC_SOURCE_BIT) ? tick_b : 1'b0;
    wire [3:0] t_tick = {tick_s, tick_s, tick_s, t1_tick};
    wire [3:0] t_hold = {3'b111, t1_mode == MODE_HOLD};

    // operand selection and legality of the pairing
    wire [1:0] src_a = cmp_ctl_r[CMP_SRC_A +: 2];
    wire [1:0] src_b = cmp_ctl_r[CMP_SRC_B +: 2];
    wire [1:0] idx_a = cmp_ctl_r[CMP_IDX_A +: 2];
    wire [1:0] idx_b = cmp_ctl_r[CMP_IDX_B +: 2];
    wire [3:0] dest_n = cmp_ctl_r[CMP_DEST +: 4];
    wire cmp_sgn = cmp_ctl_r[CMP_SIGNED];
    wire [31:0] op_a = (src_a == OPSRC_IMM) ? cmp_imm_r :
        (src_a == OPSRC_PARAM) ? par_r[idx_a] : gen_r[idx_a];
    wire [31:0] op_b = (src_b == OPSRC_PARAM) ? par_r[idx_b] : gen_r[idx_b];
    wire pair_ok = src_a != 2'h3 && src_b != 2'h3 &&
        src_b != OPSRC_IMM && dest_n <= DEST_MAX;
    wire cmp_ok = go_r && pair_ok;
    wire [2:0] cmp_res = cmp_flags(op_a, op_b, cmp_sgn);
    wire [15:0] dest_mask = 16'(16'h0007 << dest_n);
    wire [15:0] cmp_bits = 16'({13'h0000, cmp_res} << dest_n);
    wire [15:0] area_shift = bit_area_r >> last_dest_r;
    wire [2:0] area_window = area_shift[2:0];

    // read mux for the address phase
    logic [31:0] rd_val;
    always_comb begin
        rd_val = ZERO_WORD;
        if (a_addr[7:4] == OFS_SET_BASE[7:4]) begin
            rd_val = set_r[rd_idx];
        end else if (a_addr[7:4] == OFS_CUR_BASE[7:4]) begin
            rd_val = cur_r[rd_idx];
        end else if (a_addr[7:4] == OFS_GEN_BASE[7:4]) begin
            rd_val = gen_r[rd_idx];
        end else if (a_addr[7:4] == OFS_PAR_BASE[7:4]) begin
            rd_val = par_r[rd_idx];
        end else begin
            case (a_addr)
                OFS_RUN_ENABLE: rd_val = {31'h0000_0000, run_r};
                OFS_START_LINE: rd_val = {ZERO_HALF, start_line_r};
                OFS_CTRL_RESET: rd_val = {31'h0000_0000, ctl_rst_r};
                OFS_T1_CONFIG: rd_val = {ZERO_HALF, t1_cfg_r};
                OFS_CMP_CONTROL: rd_val = {ZERO_HALF, cmp_ctl_r};
                OFS_CMP_IMMEDIATE: rd_val = cmp_imm_r;
                OFS_BIT_AREA: rd_val = {ZERO_HALF, bit_area_r};
                OFS_STATUS: rd_val = {program_line_r, 14'h0000,
                    err_r, running};
                default: rd_val = ZERO_WORD;
            endcase
        end
    end

    // bus pipeline; read data is caught in the address phase edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= ZERO_WORD;
        end else begin
            wr_r <= wr_set;
            wr_addr_r <= a_addr;
            if (rd_set) begin
                hrdata_r <= (unmapped || hsize != 3'b010) ? ZERO_WORD :
                    rd_val;
            end
        end
    end

    // run, start line, reset request and timer1 configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_r <= 1'b0;
            start_line_r <= ZERO_HALF;
            ctl_rst_r <= 1'b0;
            t1_cfg_r <= ZERO_HALF;
        end else begin
            if (w_run && hwdata[31:1] == 31'h0000_0000) begin
                run_r <= hwdata[0];
            end
            if (w_line && hwdata[31:16] == ZERO_HALF &&
                hwdata[15:0] <= START_LINE_MAX) begin
                start_line_r <= hwdata[15:0];
            end
            if (w_crst && hwdata[31:1] == 31'h0000_0000) begin
                ctl_rst_r <= hwdata[0];
            end
            if (w_cfg) begin
                t1_cfg_r <= hwdata[15:0];
            end
        end
    end

    // program line latches the start line on each start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            running_d_r <= 1'b0;
            program_line_r <= ZERO_HALF;
        end else begin
            running_d_r <= running;
            if (run_rise) begin
                program_line_r <= start_line_r;
            end
        end
    end

    // tick prescalers; cleared while stopped so a start gives a full tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prescale_s_r <= ZERO_WORD;
            prescale_l_r <= ZERO_WORD;
        end else begin
            prescale_s_r <= (!running || tick_s) ? ZERO_WORD :
                prescale_s_r + 32'h0000_0001;
            prescale_l_r <= (!running || tick_l) ? ZERO_WORD :
                prescale_l_r + 32'h0000_0001;
        end
    end

    // source bit synchroniser and edge history
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_meta_r <= 1'b0;
            src_sync_r <= 1'b0;
            src_prev_r <= 1'b0;
        end else begin
            src_meta_r <= timer1_source_bit;
            src_sync_r <= src_meta_r;
            src_prev_r <= src_sync_r;
        end
    end

    // set values, current values and the operand areas
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 4; i++) begin
                set_r[i] <= ZERO_WORD;
                cur_r[i] <= ZERO_WORD;
                gen_r[i] <= ZERO_WORD;
                par_r[i] <= ZERO_WORD;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (ctl_rst_r) begin
                    cur_r[i] <= ZERO_WORD;
                end else begin
                    cur_r[i] <= timer_next(cur_r[i], set_r[i],
                        t_hold[i], t_tick[i]);
                end
            end
            // the one pattern outside the signed range is refused
            if (w_set && hwdata != VALUE_FORBIDDEN) begin
                set_r[wr_idx] <= hwdata;
            end
            if (w_gen) begin
                gen_r[wr_idx] <= hwdata;
            end
            if (w_par) begin
                par_r[wr_idx] <= hwdata;
            end
        end
    end

    // compare unit: launched by a control write with the go bit set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_ctl_r <= ZERO_HALF;
            cmp_imm_r <= ZERO_WORD;
            bit_area_r <= ZERO_HALF;
            err_r <= 1'b0;
            go_r <= 1'b0;
            last_dest_r <= 4'h0;
        end else begin
            go_r <= w_ctl && hwdata[CMP_GO];
            if (w_ctl) begin
                cmp_ctl_r <= hwdata[15:0];
            end
            if (w_imm) begin
                cmp_imm_r <= hwdata;
            end
            if (go_r) begin
                err_r <= !pair_ok;
            end
            // the compare result wins over a software write of the area
            if (cmp_ok) begin
                bit_area_r <= (bit_area_r & ~dest_mask) | cmp_bits;
                last_dest_r <= dest_n;
            end else if (w_bits) begin
                bit_area_r <= hwdata[15:0];
            end
        end
    end

    // outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign program_running = running;
    assign controller_reset = ctl_rst_r;
    assign program_line = program_line_r;
    assign bit_area = bit_area_r;

    // checks
    property p_cmp_lower;
        @(posedge hclk) disable iff (!hresetn)
        cmp_ok && cmp_res == 3'b001 |=> area_window == 3'b001;
    endproperty
    a_cmp_lower: assert property (p_cmp_lower)
        else $error("lower compare flags wrong");
    property p_cmp_not_lower;
        @(posedge hclk) disable iff (!hresetn)
        cmp_ok && !(cmp_sgn ? $signed(op_a) < $signed(op_b) : op_a < op_b)
        |=> area_window == 3'b100;
    endproperty
    a_cmp_not_lower: assert property (p_cmp_not_lower)
        else $error("higher or equal compare flags wrong");
    property p_unsigned;
        @(posedge hclk) disable iff (!hresetn)
        cmp_ok && !cmp_sgn && op_a[31] && !op_b[31] |=> area_window[2];
    endproperty
    a_unsigned: assert property (p_unsigned)
        else $error("unsigned compare misread top bit");
    property p_signed;
        @(posedge hclk) disable iff (!hresetn)
        cmp_ok && cmp_sgn && op_a[31] && !op_b[31] |=> area_window[0];
    endproperty
    a_signed: assert property (p_signed)
        else $error("signed compare misread sign");
    property p_imm_second;
        @(posedge hclk) disable iff (!hresetn)
        go_r && src_b == OPSRC_IMM |=> $stable(bit_area_r) && err_r;
    endproperty
    a_imm_second: assert property (p_imm_second)
        else $error("constant second operand accepted");
    property p_stopped;
        @(posedge hclk) disable iff (!hresetn)
        !run_r && !ctl_rst_r ##1 !ctl_rst_r |-> $stable(cur_r[0]);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("timer moved while stopped");
    property p_ctl_reset;
        @(posedge hclk) disable iff (!hresetn)
        ctl_rst_r |-> !program_running ##1 cur_r[1] == ZERO_WORD;
    endproperty
    a_ctl_reset: assert property (p_ctl_reset)
        else $error("controller reset did not clear");
    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        !ctl_rst_r && t1_mode == MODE_HOLD &&
        $signed(cur_r[0]) >= $signed(set_r[0]) |=> $stable(cur_r[0]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("timer passed set value in hold mode");
    property p_step;
        @(posedge hclk) disable iff (!hresetn)
        tick_s && !ctl_rst_r && $signed(cur_r[1]) < $signed(set_r[1])
        |=> cur_r[1] == $past(cur_r[1]) + 32'h0000_0001;
    endproperty
    a_step: assert property (p_step)
        else $error("timer did not step on tick");
    property p_start;
        @(posedge hclk) disable iff (!hresetn)
        run_rise |=> program_line_r == $past(start_line_r);
    endproperty
    a_start: assert property (p_start)
        else $error("program line not loaded on start");
    c_lower: cover property (@(posedge hclk) disable iff (!hresetn)
        cmp_ok && cmp_res == 3'b001);
    c_refused: cover property (@(posedge hclk) disable iff (!hresetn)
        go_r && !pair_ok);
    c_tick: cover property (@(posedge hclk) disable iff (!hresetn)
        t1_tick && running);
endmodule
`default_nettype wire

// ---- logic/plc_pkg.sv ----
// Purpose: shared constants for the logic controller compare and timers
// Assumes: 125 MHz hclk, word-wide register access
// Notes: offsets are byte addresses on the register bus
`default_nettype none
package plc_pkg;
    // clock and tick timing
    localparam int unsigned CLK_KHZ = 125000;
    localparam int unsigned TICK_SHORT_MS = 10;
    localparam int unsigned TICK_LONG_MS = 100;
    // register byte offsets
    localparam logic [7:0] OFS_RUN_ENABLE = 8'h00;
    localparam logic [7:0] OFS_START_LINE = 8'h04;
    localparam logic [7:0] OFS_CTRL_RESET = 8'h08;
    localparam logic [7:0] OFS_T1_CONFIG = 8'h0C;
    localparam logic [7:0] OFS_SET_BASE = 8'h10;
    localparam logic [7:0] OFS_CUR_BASE = 8'h20;
    localparam logic [7:0] OFS_CMP_CONTROL = 8'h30;
    localparam logic [7:0] OFS_CMP_IMMEDIATE = 8'h34;
    localparam logic [7:0] OFS_BIT_AREA = 8'h38;
    localparam logic [7:0] OFS_STATUS = 8'h3C;
    localparam logic [7:0] OFS_GEN_BASE = 8'h40;
    localparam logic [7:0] OFS_PAR_BASE = 8'h50;
    // timer1 configuration digits
    localparam int CFG_SRC_LSB = 0;
    localparam int CFG_MODE_LSB = 4;
    localparam logic [3:0] SRC_TICK_SHORT = 4'h0;
    localparam logic [3:0] SRC_TICK_LONG = 4'h1;
    localparam logic [3:0] SRC_SOURCE_BIT = 4'h2;
    localparam logic [3:0] MODE_HOLD = 4'h0;
    // compare control fields
    localparam int CMP_GO = 0;
    localparam int CMP_SIGNED = 1;
    localparam int CMP_SRC_A = 2;
    localparam int CMP_SRC_B = 4;
    localparam int CMP_IDX_A = 6;
    localparam int CMP_IDX_B = 8;
    localparam int CMP_DEST = 10;
    localparam logic [1:0] OPSRC_REG = 2'h0;
    localparam logic [1:0] OPSRC_PARAM = 2'h1;
    localparam logic [1:0] OPSRC_IMM = 2'h2;
    localparam logic [3:0] DEST_MAX = 4'hD;
    // status fields
    localparam int STAT_RUN = 0;
    localparam int STAT_ERR = 1;
    localparam int STAT_LINE = 16;
    // value limits and reset values
    localparam logic [15:0] START_LINE_MAX = 16'h07D0;
    localparam logic [31:0] VALUE_MAX = 32'h7FFF_FFFF;
    localparam logic [31:0] VALUE_FORBIDDEN = 32'h8000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [15:0] ZERO_HALF = 16'h0000;
endpackage
`default_nettype wire

// ---- verif/plc_compare_and_timers_tb.sv ----
// Purpose: self-checking bench for compare unit, run control and timers
// Assumes: short tick parameters, zero wait state register bus
// Notes: expected values come from bench functions; only the stopped-timer check reuses a value read back
`timescale 1ns/100ps
`default_nettype none
module plc_compare_and_timers_tb;
    import plc_pkg::*;
    // short ticks keep the run brief; expectations scale from these
    localparam int unsigned T_SHORT = 8;
    localparam int unsigned T_LONG = 20;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic src_bit = 1'b0;
    logic program_running;
    logic controller_reset;
    logic [15:0] program_line;
    logic [15:0] bit_area;
    int miscompares = 0;
    int check_count = 0;
    logic [31:0] q;
    logic [31:0] a;
    // legal operand source pairs, first operand may be the constant
    logic [1:0] sa_t [6] = '{OPSRC_REG, OPSRC_IMM, OPSRC_PARAM, OPSRC_IMM,
        OPSRC_REG, OPSRC_PARAM};
    logic [1:0] sb_t [6] = '{OPSRC_REG, OPSRC_REG, OPSRC_REG, OPSRC_PARAM,
        OPSRC_PARAM, OPSRC_PARAM};
    logic [31:0] ca [4] = '{32'h8000_0000, 32'hFFFF_FFFF, 32'h0000_0005,
        32'h7FFF_FFFF};
    logic [31:0] cb [4] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0005,
        32'h8000_0000};
    // the one slave drives the bus ready
    assign hready = hreadyout;

    plc_compare_and_timers #(.TICK_SHORT_CYC(T_SHORT),
        .TICK_LONG_CYC(T_LONG)) u_plc_compare_and_timers (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .timer1_source_bit(src_bit),
        .program_running(program_running),
        .controller_reset(controller_reset), .program_line(program_line),
        .bit_area(bit_area));

    initial begin
        forever #4 hclk = ~hclk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // bounded wait for hready sampled high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1) begin
            check("hready wait", 32'(hready), 32'h0000_0001);
            results();
        end
    endtask

    // one single word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] ofs,
        input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, ofs};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rdat = hrdata;
        check("hresp", 32'(hresp), ZERO_WORD);
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, ofs, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, ofs, ~exp, x);
        check($sformatf("reg %h", ofs), x, exp);
    endtask

    function automatic logic [7:0] ofs_of(input logic [1:0] s,
        input logic [1:0] i);
        if (s == OPSRC_IMM) begin
            return OFS_CMP_IMMEDIATE;
        end
        return (s == OPSRC_REG ? OFS_GEN_BASE : OFS_PAR_BASE) + {i, 2'b00};
    endfunction

    // lower sets bit n, otherwise bit n+2; middle bit always clear
    function automatic logic [2:0] flags(input logic [31:0] x,
        input logic [31:0] y, input logic sgn);
        logic lower;
        lower = sgn ? ($signed(x) < $signed(y)) : (x < y);
        return lower ? 3'b001 : 3'b100;
    endfunction

    // one compare; an immediate second operand must leave bits alone
    task automatic cmp(input logic [31:0] x, input logic [31:0] y,
        input logic sgn, input logic [1:0] sa, input logic [1:0] sb);
        logic [1:0] ia;
        logic [1:0] ib;
        logic [3:0] n;
        logic [15:0] prior;
        logic [15:0] exp;
        ia = 2'($urandom_range(0, 3));
        ib = ia + 2'h1;
        n = 4'($urandom_range(0, 13));
        prior = 16'($urandom);
        wr(ofs_of(sa, ia), x);
        wr(ofs_of(sb, ib), y);
        wr(OFS_BIT_AREA, {16'h0000, prior});
        wr(OFS_CMP_CONTROL, {18'h0, n, ib, ia, sb, sa, sgn, 1'b1});
        repeat (3) @(posedge hclk);
        exp = (prior & ~(16'h0007 << n)) | (16'(flags(x, y, sgn)) << n);
        if (sb == OPSRC_IMM) begin
            exp = prior;
        end
        rd_chk(OFS_BIT_AREA, {16'h0000, exp});
        check("bit_area port", 32'(bit_area), 32'(exp));
    endtask

    initial begin
        void'($urandom(79941));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, refused values, read-only and unmapped places
        for (int i = 0; i < 12; i++) begin
            rd_chk(8'(4 * i), ZERO_WORD);
        end
        wr(OFS_RUN_ENABLE, 32'h0000_0002);
        rd_chk(OFS_RUN_ENABLE, ZERO_WORD);
        wr(OFS_CTRL_RESET, 32'h0000_0003);
        rd_chk(OFS_CTRL_RESET, ZERO_WORD);
        wr(OFS_START_LINE, 32'h0000_07D1);
        rd_chk(OFS_START_LINE, ZERO_WORD);
        wr(OFS_START_LINE, 32'h0000_07D0);
        rd_chk(OFS_START_LINE, 32'h0000_07D0);
        wr(OFS_SET_BASE, VALUE_FORBIDDEN);
        rd_chk(OFS_SET_BASE, ZERO_WORD);
        wr(OFS_SET_BASE, 32'h8000_0001);
        rd_chk(OFS_SET_BASE, 32'h8000_0001);
        wr(OFS_CUR_BASE, 32'h0000_0055);
        rd_chk(OFS_CUR_BASE, ZERO_WORD);
        rd_chk(8'h60, ZERO_WORD);
        $display("test registers done");
        // corner operands both ways, then random ones with equal pairs
        for (int i = 0; i < 8; i++) begin
            cmp(ca[i % 4], cb[i % 4], 1'(i / 4), sa_t[i % 6], sb_t[i % 6]);
        end
        for (int i = 0; i < 24; i++) begin
            a = $urandom;
            cmp(a, (i % 4 == 0) ? a : $urandom, 1'(i % 2), sa_t[i % 6],
                sb_t[$urandom_range(0, 5)]);
        end
        cmp(32'h0000_0001, 32'h0000_0002, 1'b0, OPSRC_REG, OPSRC_IMM);
        bus(1'b0, OFS_STATUS, ZERO_WORD, q);
        check("compare error", 32'(q[STAT_ERR]), 32'h0000_0001);
        $display("test compare done");
        // hold mode on all four timers, then a new set value takes hold
        for (int i = 0; i < 4; i++) begin
            wr(OFS_SET_BASE + 8'(4 * i), 32'(i + 2));
        end
        wr(OFS_RUN_ENABLE, 32'h0000_0001);
        // the line is loaded one edge after running rises
        @(posedge hclk);
        #1;
        check("running", 32'(program_running), 32'h0000_0001);
        check("line", 32'(program_line), 32'h0000_07D0);
        repeat (100) @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            rd_chk(OFS_CUR_BASE + 8'(4 * i), 32'(i + 2));
        end
        wr(OFS_SET_BASE + 8'h04, 32'h0000_0007);
        repeat (100) @(posedge hclk);
        rd_chk(OFS_CUR_BASE + 8'h04, 32'h0000_0007);
        $display("test hold done");
        // tick rates in count-on mode, restarted by controller reset
        for (int s = 0; s < 2; s++) begin
            wr(OFS_CTRL_RESET, 32'h0000_0001);
            #1;
            check("ctrl reset", 32'(controller_reset), 32'h0000_0001);
            check("held", 32'(program_running), ZERO_WORD);
            rd_chk(OFS_CUR_BASE, ZERO_WORD);
            wr(OFS_T1_CONFIG, 32'h0000_0010 | 32'(s));
            wr(OFS_START_LINE, 32'(9 + s));
            wr(OFS_CTRL_RESET, ZERO_WORD);
            @(posedge hclk);
            #1;
            check("restart line", 32'(program_line), 32'(9 + s));
            repeat (10 * (s == 1 ? T_LONG : T_SHORT)) @(posedge hclk);
            bus(1'b0, OFS_CUR_BASE, ZERO_WORD, q);
            check("tick count", 32'(q >= 9 && q <= 11), 1);
        end
        wr(OFS_RUN_ENABLE, ZERO_WORD);
        bus(1'b0, OFS_CUR_BASE, ZERO_WORD, q);
        repeat (60) @(posedge hclk);
        rd_chk(OFS_CUR_BASE, q);
        $display("test rates done");
        // count edges of the source bit, past the set value of 2
        wr(OFS_CTRL_RESET, 32'h0000_0001);
        wr(OFS_T1_CONFIG, 32'h0000_0012);
        wr(OFS_CTRL_RESET, ZERO_WORD);
        wr(OFS_RUN_ENABLE, 32'h0000_0001);
        for (int i = 0; i < 5; i++) begin
            repeat (4) @(posedge hclk);
            src_bit <= 1'b1;
            repeat (4) @(posedge hclk);
            src_bit <= 1'b0;
        end
        repeat (8) @(posedge hclk);
        rd_chk(OFS_CUR_BASE, 32'h0000_0005);
        $display("test source bit done");
        results();
    end
endmodule
`default_nettype wire
